// ==== fa_flash_ecc.sv ====
// module: flash array model with per-unit ECC behind AXI4-Lite
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// ****************************************
// Functional notes
// - hamming code made on program, used on read
// - one code guards one aligned 16-byte unit
// - program stores 8 check bits, hidden
// - reads check each programmed unit with ECC on
// - single flipped bit corrected before return
// - first program codes the whole unit
// - sec mode reprogram disables unit ECC, flags it
// - only sector erase re-enables unit ECC
// - sec mode accepts byte reprograms, unit unprotected
// - delivery default is double-bit detection mode
// - ded mode corrects single, reports double
// - ded mode keeps a 9-bit code
// - ded mode refuses reprogram, program error
// - mode switch invalidates stored array contents
// - reads after unerased mode switch undefined
// - 16-byte unit is smallest protected granule
// - config bit 3 selects ded; else no double
// - unit status bit 3 double detected
// - unit status bit 1 single corrected
// - unit status bit 0 ECC off for unit
// ****************************************
module fa_flash_ecc #(
   parameter int NUM_UNITS = 8, // data units in the array model
   parameter int UNITS_PER_SECTOR = 4 // units cleared by one erase
) (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   // write address channel
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [fa_pkg::AXI_AW-1:0] I_AWADDR,
   // write data channel
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // write response channel
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // read address channel
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [fa_pkg::AXI_AW-1:0] I_ARADDR,
   // read data channel
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP
);
   import fa_pkg::*;
   localparam int UW = $clog2(NUM_UNITS); // unit index width

   // unit index must never point past the array, sectors must tile it
   if (NUM_UNITS < 2 || NUM_UNITS > 256 || UNITS_PER_SECTOR < 1 ||
       (NUM_UNITS & (NUM_UNITS - 1)) != 0 ||
       NUM_UNITS % UNITS_PER_SECTOR != 0) begin : g_bad_size
      $error("fa_flash_ecc: units must be a power of two in whole sectors");
   end

   // ****************************************
   // helpers
   // ****************************************
   // mapped word: aligned and inside the register block
   function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFF_LAST);
   endfunction
   // byte-lane merge of a bus write into a register word
   function automatic logic [31:0] merge_be(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = n[8*b +: 8];
      end
      return r;
   endfunction

   // ****************************************
   // state
   // ****************************************
   // bus slave
   logic aw_rdy_q; // write address slot free
   logic w_rdy_q; // write data slot free
   logic bvalid_q; // write answer pending
   logic [1:0] bresp_q; // write answer code
   logic [AXI_AW-1:0] aw_addr_q; // parked write address
   logic [31:0] wdata_q; // parked write data
   logic [3:0] wstrb_q; // parked byte strobes
   logic ar_rdy_q; // read address slot free
   logic rvalid_q; // read answer pending
   logic [31:0] rdata_q; // read answer word
   logic [1:0] rresp_q; // read answer code
   // software registers
   logic mode_q; // ecc mode, 1 = double-bit detection
   logic [UW-1:0] unit_q; // addressed data unit
   logic [31:0] wdat_q [4]; // program data words
   logic [BYTES-1:0] mask_q; // bytes taking part in a program
   logic [17:0] inj_q; // read path bit flips
   logic [31:0] res_q [4]; // corrected read data
   logic [7:0] ustat_q; // unit_ecc_status_byte of last read
   logic perr_q; // sticky program error
   fa_state_t state_q; // engine state
   // array model
   logic [DATA_W-1:0] mem_q [NUM_UNITS]; // unit data cells
   logic [CODE_W-1:0] code_q [NUM_UNITS]; // hidden check code cells
   logic prog_q [NUM_UNITS]; // unit written since erase
   logic off_q [NUM_UNITS]; // unit_ecc_disabled_flag cells

   // ****************************************
   // register decode
   // ****************************************
   logic wr_go; // both halves of a write are parked
   logic aw_map; // parked write address is mapped
   logic [31:0] rf [16]; // register read view by word index
   logic [31:0] wr_val; // merged value of the write
   logic [1:0] didx; // program data word index
   logic wr_cfg, wr_unit, wr_dat, wr_mask, wr_cmd, wr_stat, wr_inj;
   logic busy; // engine away from idle

   assign busy = (state_q != ST_IDLE);
   assign wr_go = ~aw_rdy_q & ~w_rdy_q & ~bvalid_q;
   assign aw_map = addr_ok(aw_addr_q);
   assign didx = aw_addr_q[3:2] - 2'd2;
   assign wr_cfg = wr_go & (aw_addr_q == OFF_CFG4);
   assign wr_unit = wr_go & (aw_addr_q == OFF_UNIT);
   assign wr_dat = wr_go & aw_map & (aw_addr_q >= OFF_DATA0) &
                   (aw_addr_q <= OFF_DATA3);
   assign wr_mask = wr_go & (aw_addr_q == OFF_MASK);
   assign wr_cmd = wr_go & (aw_addr_q == OFF_CMD);
   assign wr_stat = wr_go & (aw_addr_q == OFF_STAT);
   assign wr_inj = wr_go & (aw_addr_q == OFF_INJ);
   // read view, reserved bits read zero
   assign rf[0] = {28'h000_0000, mode_q, 3'b000};
   assign rf[1] = 32'(unit_q);
   assign rf[2] = wdat_q[0];
   assign rf[3] = wdat_q[1];
   assign rf[4] = wdat_q[2];
   assign rf[5] = wdat_q[3];
   assign rf[6] = {16'h0000, mask_q};
   assign rf[7] = 32'h0000_0000;
   assign rf[8] = {22'h00_0000, perr_q, busy, ustat_q};
   assign rf[9] = {14'h0000, inj_q};
   assign rf[10] = res_q[0];
   assign rf[11] = res_q[1];
   assign rf[12] = res_q[2];
   assign rf[13] = res_q[3];
   assign rf[14] = 32'h0000_0000;
   assign rf[15] = 32'h0000_0000;
   assign wr_val = merge_be(rf[aw_addr_q[5:2]], wdata_q, wstrb_q);

   // ****************************************
   // array data path
   // ****************************************
   logic st_prog, st_read, st_erase; // engine acts this cycle
   logic [DATA_W-1:0] cur; // addressed unit cells
   logic [DATA_W-1:0] prog_word; // program data, unmasked bytes high
   logic [DATA_W-1:0] prog_val; // cells can only go from one to zero
   logic [CODE_W-1:0] enc_code; // code of the programmed unit
   logic [CODE_W-1:0] enc_store; // code as kept for the mode
   logic [DATA_W-1:0] inj_mask; // bits flipped on the way out
   logic dec_en; // unit is programmed with ECC on
   logic [DATA_W-1:0] dec_data; // corrected unit
   logic dec_cor, dec_dbl; // decoder flags
   logic reprog; // unit already holds data
   logic [NUM_UNITS-1:0] ers_hit, prg_first, prg_again;

   assign st_prog = (state_q == ST_PROG);
   assign st_read = (state_q == ST_READ);
   assign st_erase = (state_q == ST_ERASE);
   assign cur = mem_q[unit_q];
   assign reprog = prog_q[unit_q];
   assign dec_en = prog_q[unit_q] & ~off_q[unit_q];
   // the 16-byte unit is the granule; bytes outside the mask keep their cell values
   for (genvar b = 0; b < BYTES; b++) begin : g_byte
      assign prog_word[8*b +: 8] = mask_q[b] ?
         wdat_q[b/4][8*(b%4) +: 8] : 8'hFF;
   end
   assign prog_val = cur & prog_word;
   // code covers the whole unit, however few bytes were written
   fa_secded_enc u_enc (
      .i_data(prog_val),
      .o_code(enc_code)
   );
   // sec mode keeps 8 check bits, ded mode adds parity
   assign enc_store = {mode_q & enc_code[CODE_W-1], enc_code[CHK_W-1:0]};
   assign inj_mask =
      (DATA_W'(inj_q[INJ_EN_A]) << inj_q[6:0]) |
      (DATA_W'(inj_q[INJ_EN_B]) << inj_q[14:8]);
   // reads of programmed units with ECC on are checked against the stored code
   fa_secded_dec u_dec (
      .i_data(cur ^ inj_mask),
      .i_code(code_q[unit_q]),
      .i_en(dec_en),
      .i_ded(mode_q),
      .o_data(dec_data),
      .o_cor(dec_cor),
      .o_dbl(dec_dbl)
   );
   // per unit program and erase decisions
   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      assign ers_hit[u] = st_erase &&
         (u / UNITS_PER_SECTOR == int'(unit_q) / UNITS_PER_SECTOR);
      assign prg_first[u] = st_prog && (int'(unit_q) == u) && !prog_q[u];
      // reprogram only in sec mode; ded mode refuses it
      assign prg_again[u] = st_prog && (int'(unit_q) == u) &&
         prog_q[u] && !mode_q;
   end

   // ****************************************
   // array cells
   // ****************************************
   // erase wins, then first program, then a reprogram
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            mem_q[u] <= '1;
            code_q[u] <= '0;
            prog_q[u] <= 1'b0;
            off_q[u] <= 1'b0;
         end
      end else begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            if (ers_hit[u]) begin
               // sector erase is the only way back to ECC on
               mem_q[u] <= '1;
               code_q[u] <= '0;
               prog_q[u] <= 1'b0;
               off_q[u] <= 1'b0;
            end else if (prg_first[u]) begin
               mem_q[u] <= prog_val;
               code_q[u] <= enc_store;
               prog_q[u] <= 1'b1;
            end else if (prg_again[u]) begin
               mem_q[u] <= prog_val;
               off_q[u] <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // engine and software registers
   // ****************************************
   // a command runs one cycle; commands while busy are dropped
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_q <= ST_IDLE;
      end else if (busy) begin
         state_q <= ST_IDLE;
      end else if (wr_cmd) begin
         state_q <= fa_state_t'(wr_val[1:0]);
      end
   end
   // mode bit: no erase here, stale codes are the host's care
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         mode_q <= CFG_MODE_RST;
      end else if (wr_cfg) begin
         mode_q <= wr_val[CFG_MODE_BIT];
      end
   end
   // addressing, data, mask and flip controls
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         unit_q <= '0;
         wdat_q <= '{default: 32'h0000_0000};
         mask_q <= '0;
         inj_q <= '0;
      end else begin
         if (wr_unit) unit_q <= wr_val[UW-1:0];
         if (wr_dat) wdat_q[didx] <= wr_val;
         if (wr_mask) mask_q <= wr_val[BYTES-1:0];
         if (wr_inj) inj_q <= wr_val[17:0];
      end
   end
   // program error: a refused reprogram sets it, set beats clear
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         perr_q <= 1'b0;
      end else if (st_prog && reprog && mode_q) begin
         perr_q <= 1'b1;
      end else if (wr_stat && wdata_q[STAT_PERR_BIT] &&
                   wstrb_q[STAT_PERR_BIT/8]) begin
         perr_q <= 1'b0;
      end
   end
   // read result and unit status byte
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         res_q <= '{default: 32'h0000_0000};
         ustat_q <= 8'h00;
      end else if (st_read) begin
         for (int w = 0; w < 4; w++) res_q[w] <= dec_data[32*w +: 32];
         ustat_q <= 8'h00;
         ustat_q[US_DBL] <= dec_dbl & mode_q;
         ustat_q[US_COR] <= dec_cor;
         ustat_q[US_OFF] <= off_q[unit_q];
      end
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   // write address and data park until both are here
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         aw_rdy_q <= 1'b1;
         w_rdy_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         aw_addr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (aw_rdy_q && I_AWVALID) begin
            aw_rdy_q <= 1'b0;
            aw_addr_q <= I_AWADDR;
         end
         if (w_rdy_q && I_WVALID) begin
            w_rdy_q <= 1'b0;
            wdata_q <= I_WDATA;
            wstrb_q <= I_WSTRB;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_map ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
         end
      end
   end
   // reads answer one cycle after the address is taken
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ar_rdy_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (ar_rdy_q && I_ARVALID) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= addr_ok(I_ARADDR) ? rf[I_ARADDR[5:2]] : 32'h0000_0000;
         rresp_q <= addr_ok(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && I_RREADY) begin
         rvalid_q <= 1'b0;
         ar_rdy_q <= 1'b1;
      end
   end
   assign O_AWREADY = aw_rdy_q;
   assign O_WREADY = w_rdy_q;
   assign O_BVALID = bvalid_q;
   assign O_BRESP = bresp_q;
   assign O_ARREADY = ar_rdy_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA = rdata_q;
   assign O_RRESP = rresp_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   logic one_flip, two_flip; // helper: injected error shape
   assign one_flip = inj_q[INJ_EN_A] ^ inj_q[INJ_EN_B];
   assign two_flip = inj_q[INJ_EN_A] & inj_q[INJ_EN_B] &
                     (inj_q[6:0] != inj_q[14:8]);
   AST_FIRST_CODE: assert property (
      st_prog && !reprog |=> prog_q[$past(unit_q)] &&
      code_q[$past(unit_q)] == $past(enc_store))
      else $error("first program did not store the unit code");
   AST_SEC_CODE_W: assert property (
      st_prog && !reprog && !mode_q |=> !code_q[$past(unit_q)][CHK_W])
      else $error("sec mode stored a parity bit");
   AST_SEC_REPROG: assert property (
      st_prog && reprog && !mode_q |=> off_q[$past(unit_q)] &&
      mem_q[$past(unit_q)] == $past(prog_val))
      else $error("sec reprogram did not disable unit ECC");
   AST_DED_REFUSE: assert property (
      st_prog && reprog && mode_q |=> perr_q &&
      mem_q[$past(unit_q)] == $past(cur) && !off_q[$past(unit_q)])
      else $error("ded reprogram was not refused");
   // unit 1 is the one that software reprograms and then erases
   AST_OFF_ERASE: assert property (
      $fell(off_q[1]) |-> $past(ers_hit[1]))
      else $error("unit ECC came back without erase");
   AST_SINGLE_FIX: assert property (
      st_read && dec_en && one_flip |=> ustat_q[US_COR] &&
      {res_q[3], res_q[2], res_q[1], res_q[0]} == $past(cur))
      else $error("single flipped bit not corrected");
   AST_DOUBLE_SEEN: assert property (
      st_read && dec_en && mode_q && two_flip |=>
      ustat_q[US_DBL] && !ustat_q[US_COR])
      else $error("double error not reported");
   AST_SEC_NO_DBL: assert property (
      st_read && !mode_q |=> !ustat_q[US_DBL])
      else $error("double flag set in sec mode");
   AST_OFF_FLAG: assert property (
      st_read |=> ustat_q[US_OFF] == $past(off_q[unit_q]) &&
      ustat_q[7:4] == 4'h0 && !ustat_q[2])
      else $error("unit status byte wrong");
   AST_CMD_ONE: assert property (
      busy |=> !busy)
      else $error("engine held a command past one cycle");
   COV_PROG: cover property (st_prog ##1 !busy ##[1:40] st_read);
   COV_FIX: cover property (st_read && dec_en && dec_cor);
   COV_DBL: cover property (st_read && dec_en && dec_dbl);
endmodule

// ==== fa_pkg.sv ====
// package: offsets, fields, states and code helpers of the flash ECC block
package fa_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int DATA_W = 128; // one data unit, sixteen bytes
   localparam int BYTES = 16; // bytes in a data unit
   localparam int CHK_W = 8; // hamming check bits
   localparam int CODE_W = 9; // check bits plus overall parity
   localparam int AXI_AW = 8; // register bus address width
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CFG4 = 8'h00; // volatile_config_four
   localparam logic [7:0] OFF_UNIT = 8'h04; // addressed data unit
   localparam logic [7:0] OFF_DATA0 = 8'h08; // program data, low word
   localparam logic [7:0] OFF_DATA3 = 8'h14; // program data, high word
   localparam logic [7:0] OFF_MASK = 8'h18; // byte enables of a program
   localparam logic [7:0] OFF_CMD = 8'h1C; // command strobe
   localparam logic [7:0] OFF_STAT = 8'h20; // status and unit status byte
   localparam logic [7:0] OFF_INJ = 8'h24; // read path bit flips
   localparam logic [7:0] OFF_RES0 = 8'h28; // read result, low word
   localparam logic [7:0] OFF_LAST = 8'h34; // read result, high word
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int CFG_MODE_BIT = 3; // 1 = double-bit detection mode
   localparam logic CFG_MODE_RST = 1'b1; // delivered in detection mode
   localparam int STAT_BUSY_BIT = 8; // command in progress
   localparam int STAT_PERR_BIT = 9; // program error, write one clears
   localparam int US_DBL = 3; // double_bit_detected_flag
   localparam int US_COR = 1; // single_bit_corrected_flag
   localparam int US_OFF = 0; // unit_ecc_disabled_flag
   localparam int INJ_EN_A = 16; // enable of first flip
   localparam int INJ_EN_B = 17; // enable of second flip
   localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer, fine
   localparam logic [1:0] RESP_SLVERR = 2'h2; // bus answer, unmapped
   // ****************************************
   // command codes double as engine states
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PROG = 2'b01,
      ST_READ = 2'b10,
      ST_ERASE = 2'b11
   } fa_state_t;
   // hamming position of data bit idx: skips powers of two
   function automatic logic [CHK_W-1:0] fa_data_pos(input int idx);
      int n;
      logic [CHK_W-1:0] pos;
      n = 0;
      pos = '0;
      for (int p = 3; p < 256; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == idx) pos = CHK_W'(p);
            n++;
         end
      end
      return pos;
   endfunction
endpackage

// ==== fa_secded_enc.sv ====
// module: check code generator for one sixteen-byte data unit
`timescale 1ns/1ps
module fa_secded_enc (
   // data unit in
   input wire logic [fa_pkg::DATA_W-1:0] i_data,
   // check bits and overall parity out
   output logic [fa_pkg::CODE_W-1:0] o_code
);
   import fa_pkg::*;
   logic [CHK_W-1:0] chk; // xor of positions of the set data bits
   // fold every set data bit into the check vector
   always_comb begin
      chk = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (i_data[i]) chk = chk ^ fa_data_pos(i);
      end
   end
   // overall parity makes data, check and parity even
   assign o_code = {(^i_data) ^ (^chk), chk};
endmodule

// ==== fa_secded_dec.sv ====
// module: syndrome check and correction of one data unit
`timescale 1ns/1ps
module fa_secded_dec (
   // stored unit and its code
   input wire logic [fa_pkg::DATA_W-1:0] i_data,
   input wire logic [fa_pkg::CODE_W-1:0] i_code,
   // control
   input wire logic i_en,
   input wire logic i_ded,
   // result
   output logic [fa_pkg::DATA_W-1:0] o_data,
   output logic o_cor,
   output logic o_dbl
);
   import fa_pkg::*;
   logic [CHK_W-1:0] syn; // zero when data and check bits agree
   logic [DATA_W-1:0] flip; // bit to invert
   logic par_bad; // overall parity broken
   logic syn_nz; // some position disagrees
   logic fix; // single error to correct
   // syndrome: stored check xor recomputed check
   always_comb begin
      syn = i_code[CHK_W-1:0];
      for (int i = 0; i < DATA_W; i++) begin
         if (i_data[i]) syn = syn ^ fa_data_pos(i);
      end
   end
   assign par_bad = ^{i_data, i_code};
   assign syn_nz = |syn;
   // sec mode trusts the syndrome, ded mode needs broken parity
   assign fix = i_en & (i_ded ? par_bad : syn_nz);
   assign o_cor = fix;
   assign o_dbl = i_en & i_ded & syn_nz & ~par_bad;
   // invert the data bit whose position matches the syndrome
   always_comb begin
      for (int i = 0; i < DATA_W; i++) begin
         flip[i] = fix & (fa_data_pos(i) == syn);
      end
   end
   assign o_data = i_data ^ flip;
endmodule

// ==== fa_host_bfm.sv ====
// host bus model: AXI4-Lite master that reaches the flash ECC registers
`timescale 1ns/1ps
module fa_host_bfm (
   // clock
   input wire logic i_clk,
   // master side of the five channels
   output logic o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready,
   output logic [7:0] o_awaddr, o_araddr,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   // slave answers
   input wire logic i_awready, i_wready, i_bvalid, i_arready, i_rvalid,
   input wire logic [1:0] i_bresp, i_rresp,
   input wire logic [31:0] i_rdata,
   // raised when an answer never came
   output logic o_tmo
);
   // valids, addresses and data low from time zero, all byte strobes set
   initial begin
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_tmo} = '0;
      {o_awaddr, o_araddr, o_wdata} = '0;
      o_wstrb = 4'hF;
   end
   // one write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int n;
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clk);
         if (i_awready) o_awvalid <= 1'b0;
         if (i_wready) o_wvalid <= 1'b0;
         if (i_bvalid) break;
      end
      r = i_bresp;
      o_bready <= 1'b0;
      if (n == 50) o_tmo <= 1'b1;
   endtask
   // one read: address held until taken, data taken with the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      @(posedge i_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clk);
         if (i_arready) o_arvalid <= 1'b0;
         if (i_rvalid) break;
      end
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
      if (n == 50) o_tmo <= 1'b1;
   endtask
endmodule

// ==== fa_flash_ecc_tb_top.sv ====
// testbench top: ECC scenarios of the flash array block
`timescale 1ns/1ps
module fa_flash_ecc_tb_top;
   import fa_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_tmo;
   logic [7:0] o_awaddr, o_araddr;
   logic [31:0] o_wdata, i_rdata;
   logic [3:0] o_wstrb;
   logic i_awready, i_wready, i_bvalid, i_arready, i_rvalid;
   logic [1:0] i_bresp, i_rresp;
   int n_errors = 0;
   int checked = 0;
   localparam logic [127:0] PAT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] E1 = {{15{8'hFF}}, 8'h10}; // one byte written
   localparam logic [127:0] E2 = {{14{8'hFF}}, 8'h3C, 8'h10}; // second byte
   always #20 clk = ~clk;
   fa_host_bfm host_u (
      .i_clk(clk), .o_awvalid(o_awvalid), .o_wvalid(o_wvalid),
      .o_bready(o_bready), .o_arvalid(o_arvalid), .o_rready(o_rready),
      .o_awaddr(o_awaddr), .o_araddr(o_araddr), .o_wdata(o_wdata),
      .o_wstrb(o_wstrb), .i_awready(i_awready), .i_wready(i_wready),
      .i_bvalid(i_bvalid), .i_arready(i_arready), .i_rvalid(i_rvalid),
      .i_bresp(i_bresp), .i_rresp(i_rresp), .i_rdata(i_rdata),
      .o_tmo(o_tmo));
   fa_flash_ecc dut_u (
      .I_CORE_CLK(clk), .I_RST_N(rst_n),
      .I_AWVALID(o_awvalid), .O_AWREADY(i_awready), .I_AWADDR(o_awaddr),
      .I_WVALID(o_wvalid), .O_WREADY(i_wready), .I_WDATA(o_wdata),
      .I_WSTRB(o_wstrb), .O_BVALID(i_bvalid), .I_BREADY(o_bready),
      .O_BRESP(i_bresp), .I_ARVALID(o_arvalid), .O_ARREADY(i_arready),
      .I_ARADDR(o_araddr), .O_RVALID(i_rvalid), .I_RREADY(o_rready),
      .O_RDATA(i_rdata), .O_RRESP(i_rresp));
   // compare and count
   task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // register access expecting an OKAY answer
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [1:0] r;
      host_u.wr(a, d, r);
      chk("bresp", r, RESP_OKAY);
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      host_u.rd(a, d, r);
      chk("rresp", r, RESP_OKAY);
   endtask
   // program unit u with byte mask m
   task automatic prog(logic [7:0] u, logic [15:0] m, logic [127:0] d);
      wr(OFF_UNIT, u);
      for (int i = 0; i < 4; i++) wr(OFF_DATA0 + 8'(4 * i), d[32*i +: 32]);
      wr(OFF_MASK, m);
      wr(OFF_CMD, 32'h1);
   endtask
   // read unit u with read-path flips, compare data (if cd) and status
   task automatic look(logic [7:0] u, logic [31:0] inj, logic [127:0] e,
      logic [31:0] es, bit cd);
      logic [31:0] w;
      logic [127:0] got;
      wr(OFF_INJ, inj);
      wr(OFF_UNIT, u);
      wr(OFF_CMD, 32'h2);
      for (int i = 0; i < 4; i++) begin
         rd(OFF_RES0 + 8'(4 * i), w);
         got[32*i +: 32] = w;
      end
      if (cd) chk("read data", got, e);
      rd(OFF_STAT, w);
      chk("status", w, es);
   endtask
   task automatic t_reset();
      logic [31:0] w;
      rd(OFF_CFG4, w);
      chk("mode after reset", w, 32'h0000_0008);
      rd(OFF_STAT, w);
      chk("status after reset", w, 32'h0000_0000);
   endtask
   // detection mode: correct, detect, refuse a second program
   task automatic t_ded();
      logic [31:0] w;
      prog(8'h00, 16'hFFFF, PAT);
      look(8'h00, 32'h0000_0000, PAT, 32'h0000_0000, 1);
      look(8'h00, 32'h0001_0005, PAT, 32'h0000_0002, 1);
      look(8'h00, 32'h0003_4605, PAT, 32'h0000_0008, 0);
      prog(8'h00, 16'h0001, ~PAT);
      look(8'h00, 32'h0000_0000, PAT, 32'h0000_0200, 1);
      wr(OFF_STAT, 32'h0000_0200);
      rd(OFF_STAT, w);
      chk("error cleared", w, 32'h0000_0000);
   endtask
   // correction-only mode: byte programs, unit ECC off, erase restores it
   task automatic t_sec();
      logic [31:0] w;
      wr(OFF_UNIT, 8'h00);
      wr(OFF_CMD, 32'h3);
      wr(OFF_UNIT, 8'h04);
      wr(OFF_CMD, 32'h3);
      wr(OFF_CFG4, 32'h0000_0000);
      prog(8'h01, 16'h0001, E1);
      look(8'h01, 32'h0001_0064, E1, 32'h0000_0002, 1);
      wr(OFF_CMD, 32'h2);
      wr(OFF_INJ, 32'h0003_4605);
      wr(OFF_CMD, 32'h2);
      rd(OFF_STAT, w);
      chk("no double flag", w[3], 1'b0);
      prog(8'h01, 16'h0002, E2);
      look(8'h01, 32'h0000_0000, E2, 32'h0000_0001, 1);
      look(8'h01, 32'h0001_0064, E2 ^ (128'h1 << 100), 32'h1, 1);
      wr(OFF_UNIT, 8'h00);
      wr(OFF_CMD, 32'h3);
      look(8'h01, 32'h0000_0000, '1, 32'h0000_0000, 1);
      prog(8'h01, 16'hFFFF, PAT);
      look(8'h01, 32'h0001_0064, PAT, 32'h0000_0002, 1);
   endtask
   // unmapped places answer with an error
   task automatic t_bad();
      logic [31:0] w;
      logic [1:0] r;
      host_u.rd(8'h40, w, r);
      chk("unmapped read", {r, w}, {RESP_SLVERR, 32'h0000_0000});
      host_u.wr(8'h38, 32'h0000_0001, r);
      chk("unmapped write", r, RESP_SLVERR);
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ded();
      t_sec();
      t_bad();
      conclude();
   end
   // a bus answer that never came ends the run
   always @(posedge o_tmo) begin
      n_errors++;
      conclude();
   end
endmodule
